/* File: fpsu_pkg.sv */
// constants, field positions and enumerations of the fpu status and exception unit
package fpsu_pkg;
   // status word field positions
   localparam int SW_FLAG_LSB = 0;
   localparam int SW_FLAG_MSB = 5;
   localparam int SW_STACK_FAULT = 6;
   localparam int SW_ERROR_SUMMARY = 7;
   localparam int SW_COND_A = 8;
   localparam int SW_COND_B = 9;
   localparam int SW_COND_C = 10;
   localparam int SW_TOP_LSB = 11;
   localparam int SW_TOP_MSB = 13;
   localparam int SW_COND_D = 14;
   localparam int SW_BUSY = 15;
   // control word field positions
   localparam int CW_MASK_LSB = 0;
   localparam int CW_MASK_MSB = 5;
   localparam int CW_PREC_LSB = 8;
   localparam int CW_PREC_MSB = 9;
   localparam int CW_ROUND_LSB = 10;
   localparam int CW_ROUND_MSB = 11;
   // exception flag indices, listed in order of precedence
   localparam int EXC_INVALID = 0;
   localparam int EXC_DENORMAL = 1;
   localparam int EXC_ZERO_DIV = 2;
   localparam int EXC_OVERFLOW = 3;
   localparam int EXC_UNDERFLOW = 4;
   localparam int EXC_INEXACT = 5;
   localparam int EXC_COUNT = 6;
   // reset values
   localparam logic [15:0] SW_RESET = 16'h0000;
   localparam logic [15:0] CW_RESET = 16'h003f;
   localparam logic [2:0] EXC_NONE = 3'h7;
   // pointer image formats: {protected, 32-bit operand size}
   localparam logic [1:0] FMT_REAL16 = 2'h0;
   localparam logic [1:0] FMT_REAL32 = 2'h1;
   localparam logic [1:0] FMT_PROT16 = 2'h2;
   localparam logic [1:0] FMT_PROT32 = 2'h3;
   // rounding field encodings
   typedef enum logic [1:0] {
      RND_NEAREST_EVEN = 2'h0,
      RND_DOWN = 2'h1,
      RND_UP = 2'h2,
      RND_TRUNCATE = 2'h3
   } fpsu_round_t;
   // compare outcome as {cond_bit_d, cond_bit_c, cond_bit_a}
   localparam logic [2:0] CMP_GREATER = 3'h0;
   localparam logic [2:0] CMP_LESS = 3'h1;
   localparam logic [2:0] CMP_EQUAL = 3'h4;
   localparam logic [2:0] CMP_UNORDERED = 3'h7;
   // operand class as {cond_bit_d, cond_bit_c, cond_bit_a}
   localparam logic [2:0] CLS_UNSUPPORTED = 3'h0;
   localparam logic [2:0] CLS_NAN = 3'h1;
   localparam logic [2:0] CLS_NORMAL = 3'h2;
   localparam logic [2:0] CLS_INFINITY = 3'h3;
   localparam logic [2:0] CLS_ZERO = 3'h4;
   localparam logic [2:0] CLS_EMPTY = 3'h5;
   localparam logic [2:0] CLS_DENORMAL = 3'h6;
   // instruction kinds seen by this unit
   typedef enum logic [2:0] {
      OPK_OTHER,
      OPK_REMAINDER,
      OPK_COMPARE,
      OPK_EXAMINE,
      OPK_ARITH,
      OPK_ROUNDING,
      OPK_NO_ROUND
   } fpsu_op_t;
endpackage

/* File: fpsu_exception_unit.sv */
// status word, control word, exception reporting and pointer capture of the fpu
`timescale 1ns/1ns
module fpsu_exception_unit
(
   input wire logic clk,
   input wire logic reset_n,
   // completion of a numeric operation with its outcome
   input wire logic op_done,
   input wire fpsu_pkg::fpsu_op_t op_kind,
   input wire logic [5:0] exc_detect,
   input wire logic snan_operand,
   input wire logic unsupported_operand,
   input wire logic indeterminate_form,
   input wire logic stack_error,
   input wire logic stack_overflow,
   input wire logic reduction_done,
   input wire logic [2:0] quotient_low,
   input wire logic [2:0] compare_code,
   input wire logic [2:0] class_code,
   input wire logic class_sign,
   // decode of a new numeric instruction, or a wait instruction
   input wire logic instr_decode,
   input wire fpsu_pkg::fpsu_op_t decode_kind,
   input wire logic [31:0] instr_addr,
   input wire logic [10:0] instr_opcode,
   input wire logic mem_operand,
   input wire logic [31:0] operand_addr,
   input wire logic protected_mode,
   input wire logic v86_mode,
   input wire logic operand_32,
   input wire logic wait_instr,
   input wire logic native_error_select,
   // control word load and environment restore
   input wire logic cw_load,
   input wire logic [15:0] cw_wdata,
   input wire logic env_load,
   input wire logic [15:0] env_sw_data,
   input wire logic [15:0] env_cw_data,
   // register and mode outputs
   output logic [15:0] fpu_status_word,
   output logic [15:0] fpu_control_word,
   output logic fp_error_out_n,
   output logic exc16_pulse,
   output logic ext_irq_pulse,
   output logic default_valid,
   output logic [2:0] default_code,
   output logic [31:0] instr_ptr,
   output logic [31:0] operand_ptr,
   output logic [10:0] opcode_ptr,
   output logic [1:0] ptr_format,
   output logic round_apply,
   output fpsu_pkg::fpsu_round_t rounding_field,
   output logic precision_apply,
   output logic [1:0] precision_field
);
   import fpsu_pkg::*;

   logic [15:0] sw_reg, sw_next;
   logic [15:0] cw_reg, cw_next;
   logic fp_error_out_n_reg;
   logic exc16_reg, ext_irq_reg;
   logic default_valid_reg;
   logic [2:0] default_code_reg;
   logic [31:0] instr_ptr_reg, operand_ptr_reg;
   logic [10:0] opcode_ptr_reg;
   logic [1:0] ptr_format_reg;
   logic round_apply_reg, precision_apply_reg;
   logic [1:0] round_reg, prec_reg;

   // index of the highest-precedence set bit, EXC_NONE when none
   function automatic logic [2:0] first_exc(input logic [5:0] v);
      logic [2:0] idx;
      idx = EXC_NONE;
      for (int i = EXC_COUNT - 1; i >= 0; i--)
      begin
         if (v[i])
         begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction

   // summary of unmasked flags against a mask set
   function automatic logic summary(input logic [5:0] flags, input logic [5:0] masks);
      return |(flags & ~masks);
   endfunction

   // invalid operation gathered from its causes
   wire invalid_cause = exc_detect[EXC_INVALID] | snan_operand | unsupported_operand
                        | indeterminate_form | stack_error;
   wire [5:0] raw_exc = {exc_detect[5:1], invalid_cause};
   wire [2:0] top_exc = first_exc(raw_exc);
   wire [5:0] new_flags = (op_done && top_exc != EXC_NONE) ? 6'(6'h01 << top_exc) : 6'h00;

   // control word: environment restore overrides a plain control load
   wire [15:0] cw_src = env_load ? env_cw_data : cw_wdata;
   wire [5:0] masks_next = cw_next[CW_MASK_MSB:CW_MASK_LSB];
   wire top_masked = |(new_flags & masks_next); // top exception and its mask, no out-of-range index

   // flags and stack fault: a new event wins over the restored value
   wire [5:0] flags_base = env_load ? env_sw_data[SW_FLAG_MSB:SW_FLAG_LSB]
                                    : sw_reg[SW_FLAG_MSB:SW_FLAG_LSB];
   wire [5:0] flags_next = flags_base | new_flags;
   wire sf_base = env_load ? env_sw_data[SW_STACK_FAULT] : sw_reg[SW_STACK_FAULT];
   wire sf_set = op_done & stack_error & (top_exc == 3'(EXC_INVALID));
   wire es_next = summary(flags_next, masks_next);

   // pending error blocks the next numeric or wait instruction
   wire fault_now = sw_reg[SW_ERROR_SUMMARY] & (instr_decode | wait_instr);
   wire capture = instr_decode & ~fault_now;

   // pointer format: virtual-8086 falls back to the real formats
   wire prot_fmt = protected_mode & ~v86_mode;
   wire [1:0] fmt_next = prot_fmt ? (operand_32 ? FMT_PROT32 : FMT_PROT16)
                                  : (operand_32 ? FMT_REAL32 : FMT_REAL16);

   // operations that round, and those that use the precision field
   wire kind_rounds = (decode_kind == OPK_ARITH) || (decode_kind == OPK_ROUNDING);
   wire kind_prec = (decode_kind == OPK_ARITH);

   // control word next value
   always_comb
   begin
      cw_next = cw_reg;
      if (env_load || cw_load)
      begin
         cw_next = cw_src;
      end
   end

   // status word next value: condition codes, flags, summary and busy mirror
   always_comb
   begin
      sw_next = sw_reg;
      if (env_load)
      begin
         sw_next = env_sw_data;
      end
      if (op_done)
      begin
         case (op_kind)
            OPK_REMAINDER:
            begin
               if (!reduction_done)
               begin
                  sw_next[SW_COND_C] = 1'b1;
               end
               else
               begin
                  sw_next[SW_COND_C] = 1'b0;
                  sw_next[SW_COND_A] = quotient_low[2];
                  sw_next[SW_COND_D] = quotient_low[1];
                  sw_next[SW_COND_B] = quotient_low[0];
               end
            end
            OPK_COMPARE:
            begin
               sw_next[SW_COND_D] = compare_code[2];
               sw_next[SW_COND_C] = compare_code[1];
               sw_next[SW_COND_A] = compare_code[0];
            end
            OPK_EXAMINE:
            begin
               sw_next[SW_COND_D] = class_code[2];
               sw_next[SW_COND_C] = class_code[1];
               sw_next[SW_COND_A] = class_code[0];
               sw_next[SW_COND_B] = class_sign;
            end
            default:
            begin
               sw_next[SW_COND_A] = sw_next[SW_COND_A];
            end
         endcase
         if (sf_set)
         begin
            sw_next[SW_COND_B] = stack_overflow;
         end
      end
      sw_next[SW_FLAG_MSB:SW_FLAG_LSB] = flags_next;
      sw_next[SW_STACK_FAULT] = sf_base | sf_set;
      sw_next[SW_ERROR_SUMMARY] = es_next;
      sw_next[SW_BUSY] = es_next;
   end

   // status and control registers with the error pin
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         sw_reg <= SW_RESET;
         cw_reg <= CW_RESET;
         fp_error_out_n_reg <= 1'b1;
      end
      else
      begin
         sw_reg <= sw_next;
         cw_reg <= cw_next;
         fp_error_out_n_reg <= ~es_next;
      end
   end

   // fault report at the next numeric or wait instruction
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         exc16_reg <= 1'b0;
         ext_irq_reg <= 1'b0;
      end
      else
      begin
         exc16_reg <= fault_now & ~native_error_select;
         ext_irq_reg <= fault_now & native_error_select;
      end
   end

   // default action code for a masked exception
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         default_valid_reg <= 1'b0;
         default_code_reg <= EXC_NONE;
      end
      else
      begin
         default_valid_reg <= op_done & (top_exc != EXC_NONE) & top_masked;
         default_code_reg <= op_done ? top_exc : EXC_NONE;
      end
   end

   // instruction and operand pointers taken at decode
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         instr_ptr_reg <= 32'h0000_0000;
         operand_ptr_reg <= 32'h0000_0000;
         opcode_ptr_reg <= 11'h000;
         ptr_format_reg <= FMT_REAL16;
      end
      else if (capture)
      begin
         instr_ptr_reg <= instr_addr;
         opcode_ptr_reg <= instr_opcode;
         ptr_format_reg <= fmt_next;
         if (mem_operand)
         begin
            operand_ptr_reg <= operand_addr;
         end
      end
   end

   // operating mode for the decoded instruction from the control high byte
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         round_apply_reg <= 1'b0;
         precision_apply_reg <= 1'b0;
         round_reg <= RND_NEAREST_EVEN;
         prec_reg <= 2'h0;
      end
      else if (capture)
      begin
         round_apply_reg <= kind_rounds;
         precision_apply_reg <= kind_prec;
         round_reg <= cw_next[CW_ROUND_MSB:CW_ROUND_LSB];
         prec_reg <= cw_next[CW_PREC_MSB:CW_PREC_LSB];
      end
   end

   // outputs straight from the registers
   assign fpu_status_word = sw_reg;
   assign fpu_control_word = cw_reg;
   assign fp_error_out_n = fp_error_out_n_reg;
   assign exc16_pulse = exc16_reg;
   assign ext_irq_pulse = ext_irq_reg;
   assign default_valid = default_valid_reg;
   assign default_code = default_code_reg;
   assign instr_ptr = instr_ptr_reg;
   assign operand_ptr = operand_ptr_reg;
   assign opcode_ptr = opcode_ptr_reg;
   assign ptr_format = ptr_format_reg;
   assign round_apply = round_apply_reg;
   assign rounding_field = fpsu_round_t'(round_reg);
   assign precision_apply = precision_apply_reg;
   assign precision_field = prec_reg;
endmodule // fpsu_exception_unit

/* File: fpsu_properties.sv */
// checker of the fpu status and exception unit ports
`timescale 1ns/1ns
module fpsu_checker
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic op_done,
   input wire fpsu_pkg::fpsu_op_t op_kind,
   input wire logic stack_error,
   input wire logic stack_overflow,
   input wire logic reduction_done,
   input wire logic [2:0] quotient_low,
   input wire logic [2:0] compare_code,
   input wire logic instr_decode,
   input wire logic [31:0] instr_addr,
   input wire logic wait_instr,
   input wire logic native_error_select,
   input wire logic [15:0] fpu_status_word,
   input wire logic [15:0] fpu_control_word,
   input wire logic fp_error_out_n,
   input wire logic exc16_pulse,
   input wire logic ext_irq_pulse,
   input wire logic [31:0] instr_ptr
);
   import fpsu_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // a numeric or wait instruction meets a pending unmasked error
   sequence s_fault;
      (instr_decode || wait_instr) && fpu_status_word[7];
   endsequence
   // a completed op free of stack faults
   sequence s_clean_op(fpsu_op_t k);
      op_done && op_kind == k && !stack_error;
   endsequence
   a_pin_follows: assert property (fp_error_out_n == !fpu_status_word[7])
      else $error("error pin disagrees with summary");
   a_summary_exact: assert property (fpu_status_word[7] == fpu_status_word[15] &&
      fpu_status_word[7] == |(fpu_status_word[5:0] & ~fpu_control_word[5:0]))
      else $error("summary or busy mirror wrong");
   a_fault_trap: assert property (s_fault ##0 !native_error_select |=> exc16_pulse && !ext_irq_pulse ##1
      exc16_pulse == $past((instr_decode || wait_instr) && fpu_status_word[7] && !native_error_select))
      else $error("missing internal exception pulse");
   a_fault_irq: assert property (s_fault ##0 native_error_select |=> ext_irq_pulse && !exc16_pulse)
      else $error("missing external interrupt pulse");
   a_compare_code: assert property (s_clean_op(OPK_COMPARE) |=>
      {fpu_status_word[14], fpu_status_word[10], fpu_status_word[8]} == $past(compare_code))
      else $error("compare condition bits wrong");
   a_rem_partial: assert property (s_clean_op(OPK_REMAINDER) ##0 !reduction_done |=> fpu_status_word[10])
      else $error("incomplete reduction not flagged");
   a_rem_quotient: assert property (s_clean_op(OPK_REMAINDER) ##0 reduction_done |=>
      {fpu_status_word[8], fpu_status_word[14], fpu_status_word[9], fpu_status_word[10]}
      == {$past(quotient_low), 1'b0})
      else $error("quotient bits wrong");
   a_stack_fault: assert property (op_done && stack_error |=> fpu_status_word[6] &&
      fpu_status_word[0] && fpu_status_word[9] == $past(stack_overflow))
      else $error("stack fault reporting wrong");
   a_ptr_capture: assert property (instr_decode && !fpu_status_word[7] |=> instr_ptr == $past(instr_addr))
      else $error("instruction address not captured");
endmodule // fpsu_checker
bind fpsu_exception_unit fpsu_checker u_checker (.*);

/* File: fpsu_irq_model.sv */
// system interrupt logic that services the unit's fault requests
`timescale 1ns/1ns
module fpsu_irq_model
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic exc16_pulse,
   input wire logic ext_irq_pulse,
   output logic [7:0] irq_count,
   output logic [7:0] trap_count
);
   // count each serviced request once per pulse cycle
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         irq_count <= 8'h00;
         trap_count <= 8'h00;
      end
      else
      begin
         irq_count <= irq_count + {7'h00, ext_irq_pulse};
         trap_count <= trap_count + {7'h00, exc16_pulse};
      end
   end
endmodule // fpsu_irq_model

/* File: tb.sv */
// self-checking testbench of the fpu status and exception unit
`timescale 1ns/1ns
module tb;
   import fpsu_pkg::*;
   logic clk, reset_n, op_done, snan_operand, unsupported_operand, indeterminate_form;
   logic stack_error, stack_overflow, reduction_done, class_sign, instr_decode, mem_operand;
   logic protected_mode, v86_mode, operand_32, wait_instr, native_error_select, cw_load;
   logic env_load, fp_error_out_n, exc16_pulse, ext_irq_pulse, default_valid;
   logic round_apply, precision_apply;
   fpsu_op_t op_kind, decode_kind;
   fpsu_round_t rounding_field;
   logic [5:0] exc_detect;
   logic [2:0] quotient_low, compare_code, class_code, default_code;
   logic [31:0] instr_addr, operand_addr, instr_ptr, operand_ptr;
   logic [10:0] instr_opcode, opcode_ptr;
   logic [15:0] cw_wdata, env_sw_data, env_cw_data, fpu_status_word, fpu_control_word;
   logic [1:0] ptr_format, precision_field;
   logic [7:0] irq_count, trap_count;
   logic [2:0] cmp_tab [4] = '{3'h0, 3'h1, 3'h4, 3'h7};
   fpsu_op_t kind_tab [4] = '{OPK_ARITH, OPK_ROUNDING, OPK_NO_ROUND, OPK_REMAINDER};
   int fail_count, n_compared;
   fpsu_exception_unit DUT (.*);
   fpsu_irq_model model (.*);
   // free running clock
   always #4 clk = ~clk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // one completed op; c feeds compare, class and quotient inputs
   task automatic run_op(input fpsu_op_t k, input logic [5:0] e, input logic [2:0] c);
      op_kind = k;
      exc_detect = e;
      compare_code = c;
      class_code = c;
      quotient_low = c;
      op_done = 1'b1;
      @(negedge clk);
      op_done = 1'b0;
   endtask
   task automatic restore(input logic [15:0] sw, input logic [15:0] cw);
      env_sw_data = sw;
      env_cw_data = cw;
      env_load = 1'b1;
      @(negedge clk);
      env_load = 1'b0;
   endtask
   // numeric decode, or a wait instruction when w is set
   task automatic decode(input fpsu_op_t k, input logic [31:0] a, input logic w);
      decode_kind = k;
      instr_addr = a;
      operand_addr = ~a;
      instr_opcode = a[10:0];
      instr_decode = !w;
      wait_instr = w;
      @(negedge clk);
      instr_decode = 1'b0;
      wait_instr = 1'b0;
   endtask
   // guard against a hang
   initial
   begin
      #200000;
      fail_count++;
      finish_test();
   end
   initial
   begin
      clk = 1'b0;
      reset_n = 1'b0;
      {op_done, snan_operand, unsupported_operand, indeterminate_form, stack_error,
         stack_overflow, reduction_done, class_sign, instr_decode, mem_operand, protected_mode,
         v86_mode, operand_32, wait_instr, native_error_select, cw_load, env_load, exc_detect,
         quotient_low, compare_code, class_code, instr_addr, operand_addr, instr_opcode,
         cw_wdata, env_sw_data, env_cw_data} = '0;
      op_kind = OPK_OTHER;
      decode_kind = OPK_OTHER;
      fail_count = 0;
      n_compared = 0;
      repeat (3) @(negedge clk);
      reset_n = 1'b1;
      chk({fpu_status_word, fpu_control_word}, 32'h0000_003f);
      chk({fp_error_out_n, default_code}, 4'hf);
      // condition codes of compare, examine and remainder
      for (int i = 0; i < 4; i++)
      begin
         run_op(OPK_COMPARE, 6'h00, cmp_tab[i]);
         chk({fpu_status_word[14], fpu_status_word[10], fpu_status_word[8]}, cmp_tab[i]);
      end
      for (int i = 0; i < 7; i++)
      begin
         class_sign = i[0];
         run_op(OPK_EXAMINE, 6'h00, i[2:0]);
         chk({fpu_status_word[14], fpu_status_word[10], fpu_status_word[8], fpu_status_word[9]}, {i[2:0], i[0]});
      end
      reduction_done = 1'b1;
      run_op(OPK_REMAINDER, 6'h00, 3'h3);
      chk({fpu_status_word[8], fpu_status_word[14], fpu_status_word[9], fpu_status_word[10]}, 4'h6);
      reduction_done = 1'b0;
      run_op(OPK_REMAINDER, 6'h00, 3'h4);
      chk({fpu_status_word[8], fpu_status_word[14], fpu_status_word[9], fpu_status_word[10]}, 4'h7);
      // each exception unmasked, then masked, with all lower-precedence ones raised too
      for (int i = 0; i < 6; i++)
      begin
         restore(16'h0000, 16'h0000);
         run_op(OPK_ARITH, 6'h3f << i, 3'h0);
         chk({fp_error_out_n, fpu_status_word[7:0]}, 9'h080 | (9'h001 << i));
         restore(16'h0000, 16'h0001 << i);
         run_op(OPK_ARITH, 6'h3f << i, 3'h0);
         chk({default_valid, default_code}, {1'b1, i[2:0]});
         chk({fp_error_out_n, fpu_status_word[7:0]}, 9'h100 | (9'h001 << i));
      end
      // extra invalid causes, last two are stack underflow and overflow
      for (int i = 0; i < 5; i++)
      begin
         restore(16'h0000, 16'h003f);
         {stack_overflow, stack_error, indeterminate_form, unsupported_operand, snan_operand} = (i == 4) ? 5'h18 : 5'h01 << i;
         run_op(OPK_OTHER, 6'h04, 3'h0);
         chk({fpu_status_word[9], fpu_status_word[6:0]}, {i == 4, i >= 3, 6'h01});
      end
      {stack_overflow, stack_error, indeterminate_form, unsupported_operand, snan_operand} = 5'h00;
      // loaded summary and busy bits are recomputed
      restore(16'h8081, 16'h003f);
      chk({fp_error_out_n, fpu_status_word}, 17'h1_0001);
      restore(16'h0001, 16'h0000);
      chk({fp_error_out_n, fpu_status_word}, 17'h0_8081);
      // pending error faults a wait, then a decode
      decode(OPK_ARITH, 32'h0000_1234, 1'b1);
      chk({exc16_pulse, ext_irq_pulse}, 2'h2);
      native_error_select = 1'b1;
      decode(OPK_ARITH, 32'h0000_5678, 1'b0);
      chk({exc16_pulse, ext_irq_pulse}, 2'h1);
      chk(instr_ptr, 32'h0000_0000);
      @(negedge clk);
      chk({exc16_pulse, ext_irq_pulse, irq_count, trap_count}, 18'h00101);
      // pointer capture in every mode combination
      restore(16'h0000, 16'h003f);
      mem_operand = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         {v86_mode, protected_mode, operand_32} = i[2:0];
         decode(OPK_OTHER, 32'h1000_0000 + i, 1'b0);
         chk({ptr_format, opcode_ptr}, {i[1] & !i[2], i[0], 11'(i)});
         chk(operand_ptr ^ instr_ptr, 32'hffff_ffff);
      end
      // no memory operand: operand pointer keeps its stale value
      mem_operand = 1'b0;
      decode(OPK_OTHER, 32'h3000_0000, 1'b0);
      chk(instr_ptr, 32'h3000_0000);
      chk(operand_ptr, 32'hefff_fff8);
      // mode fields follow a control load in the decode cycle
      for (int i = 0; i < 4; i++)
      begin
         cw_wdata = {4'h0, i[1:0], 2'h1, 8'h3f};
         cw_load = 1'b1;
         decode(kind_tab[i], 32'h2000, 1'b0);
         cw_load = 1'b0;
         chk({round_apply, precision_apply, rounding_field, precision_field}, {i < 2, i == 0, i[1:0], 2'h1});
      end
      // second reset in mid-run
      reset_n = 1'b0;
      @(negedge clk);
      reset_n = 1'b1;
      chk({fpu_status_word, fpu_control_word}, 32'h0000_003f);
      finish_test();
   end
endmodule // tb
